// File: logic/ebc_top.sv
`timescale 1ns/10ps
`include "ebc_cfg.svh"
`default_nettype none

module ebc_top
  import ebc_pkg::*;
#(
  parameter int ADDR_W = `EBC_ADDR_W,
  parameter int DATA_W = `EBC_DATA_W,
  parameter int WAIT_W = `EBC_WAIT_W
)
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              req_valid,
  output var  logic              req_ready,
  input  wire ebc_space_t        req_space,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [WAIT_W-1:0] req_waits,
  output var  logic              rsp_done,
  output var  logic [DATA_W-1:0] rsp_rdata,
  input  wire logic              ext_ready,
  input  wire logic              bus_release_req_n,
  input  wire logic              output_float_n,
  output var  logic              data_space_select_n,
  output var  logic              program_space_select_n,
  output var  logic              io_space_select_n,
  output var  logic              space_select_oe,
  output var  logic              memory_access_strobe_n,
  output var  logic              io_access_strobe_n,
  output var  logic              strobe_oe,
  output var  logic              read_write_n,
  output var  logic              read_write_oe,
  output var  logic [ADDR_W-1:0] ext_address_lines,
  output var  logic              ext_address_oe,
  input  wire logic [DATA_W-1:0] ext_data_in,
  output var  logic [DATA_W-1:0] ext_data_lines,
  output var  logic              ext_data_oe,
  output var  logic              bus_release_ack_n,
  output var  logic              bus_release_ack_oe,
  output var  logic              wait_states_complete_n,
  output var  logic              wait_states_complete_oe
);

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_STROBE,
    ST_SWAIT,
    ST_READY,
    ST_END,
    ST_HOLD
  } ebc_state_t;

  ebc_state_t        state;
  ebc_state_t        next_state;
  ebc_space_t        space;
  logic              write;
  logic [WAIT_W-1:0] waits;
  logic [2:0]        sel_n;
  logic              mem_strb_n;
  logic              io_strb_n;
  logic              rw_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              drive_data;
  logic              bus_release_ack_n_n;
  logic              done;
  logic [DATA_W-1:0] rdata;
  logic [`EBC_PIN_W-1:0] pin_raw;
  logic [`EBC_PIN_W-1:0] pin_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign pin_raw[`EBC_PIN_READY]  = ext_ready;
  assign pin_raw[`EBC_PIN_HOLD_N] = bus_release_req_n;
  assign pin_raw[`EBC_PIN_OFF_N]  = output_float_n;

  ebc_sync
  #(
    .W   (`EBC_PIN_W),
    .RST (`EBC_PIN_RST)
  )
  u_sync
  (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (pin_raw),
    .q       (pin_q)
  );

  wire ready_q  = pin_q[`EBC_PIN_READY];
  wire hold_req = !pin_q[`EBC_PIN_HOLD_N];
  wire float_q  = !pin_q[`EBC_PIN_OFF_N];

  // ----------------------------------------
  // Software wait timer
  // ----------------------------------------
  ebc_wait_if #(.WAIT_W(WAIT_W)) wif ();

  ebc_wait
  #(
    .WAIT_W (WAIT_W)
  )
  u_wait
  (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wt      (wif)
  );

  assign wif.start = (state == ST_STROBE);
  assign wif.count = waits;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire take      = (state == ST_IDLE) && !hold_req && req_valid;
  wire in_hold   = (state == ST_HOLD);
  wire no_waits  = (waits == '0);
  wire use_ready = (waits >= WAIT_W'(`EBC_RDY_MIN_WAITS));
  wire strobing  = (next_state == ST_STROBE)
                || (next_state == ST_SWAIT)
                || (next_state == ST_READY);

  wire ebc_space_t acc_space = take ? req_space : space;
  wire acc_write = take ? req_write : write;

  // One-hot select per space, low only while strobing
  wire [2:0] sel_hot = (acc_space == EBC_SP_DATA) ? 3'h1
                     : (acc_space == EBC_SP_PROG) ? 3'h2
                     : (acc_space == EBC_SP_IO)   ? 3'h4
                     : 3'h0;
  wire [2:0] next_sel_n = strobing ? ~sel_hot
                                   : `EBC_SEL_IDLE;
  wire is_io = (acc_space == EBC_SP_IO);
  wire next_mem_strb_n = !(strobing && !is_io);
  wire next_io_strb_n  = !(strobing && is_io);
  wire next_rw_n       = !(strobing && acc_write);
  wire next_drive      = strobing && acc_write;

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (hold_req)
          next_state = ST_HOLD;
        else if (req_valid)
          next_state = ST_STROBE;
      end
      ST_STROBE:
      begin
        if (no_waits)
          next_state = ST_END;
        else
          next_state = ST_SWAIT;
      end
      ST_SWAIT:
      begin
        if (wif.done && use_ready)
          next_state = ST_READY;
        else if (wif.done)
          next_state = ST_END;
      end
      ST_READY:
      begin
        if (ready_q)
          next_state = ST_END;
      end
      ST_END:
      begin
        next_state = ST_IDLE;
      end
      ST_HOLD:
      begin
        if (!hold_req)
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------
  // Access capture
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      space <= EBC_SP_DATA;
      write <= 1'b0;
      waits <= WAIT_W'(`EBC_WAIT_RST);
      addr  <= ADDR_W'(`EBC_ADDR_RST);
      wdata <= DATA_W'(`EBC_DATA_RST);
    end
    else if (take)
    begin
      space <= req_space;
      write <= req_write;
      waits <= req_waits;
      addr  <= req_addr;
      wdata <= req_wdata;
    end
  end

  // ----------------------------------------
  // Pin output registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_n      <= `EBC_SEL_IDLE;
      mem_strb_n <= 1'b1;
      io_strb_n  <= 1'b1;
      rw_n       <= 1'b1;
      drive_data <= 1'b0;
      bus_release_ack_n_n    <= 1'b1;
    end
    else
    begin
      sel_n      <= next_sel_n;
      mem_strb_n <= next_mem_strb_n;
      io_strb_n  <= next_io_strb_n;
      rw_n       <= next_rw_n;
      drive_data <= next_drive;
      bus_release_ack_n_n    <= !(next_state == ST_HOLD);
    end
  end

  // ----------------------------------------
  // Completion and read data
  // ----------------------------------------
  wire finish = (next_state == ST_END);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      done  <= 1'b0;
      rdata <= DATA_W'(`EBC_DATA_RST);
    end
    else
    begin
      done <= finish;
      if (finish && !write)
        rdata <= ext_data_in;
    end
  end

  // ----------------------------------------
  // Output enables
  // ----------------------------------------
  wire ctl_drive = !float_q && !in_hold;
  wire bus_drive = ctl_drive && !hold_req;

  assign space_select_oe   = ctl_drive;
  assign strobe_oe         = ctl_drive;
  assign read_write_oe     = ctl_drive;
  assign ext_address_oe    = ctl_drive;
  assign ext_data_oe       = bus_drive && drive_data;
  assign bus_release_ack_oe      = !float_q;
  assign wait_states_complete_oe = !float_q;

  // ----------------------------------------
  // Pin and user outputs
  // ----------------------------------------
  assign data_space_select_n    = sel_n[0];
  assign program_space_select_n = sel_n[1];
  assign io_space_select_n      = sel_n[2];
  assign memory_access_strobe_n = mem_strb_n;
  assign io_access_strobe_n     = io_strb_n;
  assign read_write_n           = rw_n;
  assign ext_address_lines      = addr;
  assign ext_data_lines         = wdata;
  assign bus_release_ack_n      = bus_release_ack_n_n;
  assign wait_states_complete_n = !wif.msc_low;
  assign req_ready              = (state == ST_IDLE) && !hold_req;
  assign rsp_done               = done;
  assign rsp_rdata              = rdata;

endmodule // ebc_top

`default_nettype wire

// File: logic/ebc_cfg.svh
`ifndef EBC_CFG_SVH
`define EBC_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define EBC_ADDR_W 23
`define EBC_DATA_W 16
`define EBC_WAIT_W 3
`define EBC_PIN_W 3

// ----------------------------------------
// Field positions of the synchronised pins
// ----------------------------------------
`define EBC_PIN_READY 0
`define EBC_PIN_HOLD_N 1
`define EBC_PIN_OFF_N 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EBC_PIN_RST 3'h6
`define EBC_SEL_IDLE 3'h7
`define EBC_ADDR_RST 23'h000000
`define EBC_DATA_RST 16'h0000
`define EBC_WAIT_RST 3'h0

// ----------------------------------------
// Timing counts in wait states
// ----------------------------------------
`define EBC_RDY_MIN_WAITS 3'h2
`define EBC_LAST_WAIT 3'h1
`define EBC_MSC_ABOVE 3'h2

`endif

// File: logic/ebc_pkg.sv
`default_nettype none

package ebc_pkg;

  // ----------------------------------------
  // External spaces, one select each
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    EBC_SP_DATA,
    EBC_SP_PROG,
    EBC_SP_IO
  } ebc_space_t;

endpackage

`default_nettype wire

// File: logic/ebc_wait_if.sv
`timescale 1ns/10ps
`default_nettype none

interface ebc_wait_if #(parameter int WAIT_W = 3);
  logic              start;
  logic [WAIT_W-1:0] count;
  logic              busy;
  logic              done;
  logic              msc_low;

  modport ctrl
  (
    output start,
    output count,
    input  busy,
    input  done,
    input  msc_low
  );

  modport timer
  (
    input  start,
    input  count,
    output busy,
    output done,
    output msc_low
  );
endinterface // ebc_wait_if

`default_nettype wire

// File: logic/ebc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module ebc_sync
#(
  parameter int           W   = 3,
  parameter logic [W-1:0] RST = '0
)
(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  // ----------------------------------------
  // Three stages, change taken when 2 and 3 agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      wire  agree = (s2 == s3);

      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          s1   <= RST[i];
          s2   <= RST[i];
          s3   <= RST[i];
          q[i] <= RST[i];
        end
        else
        begin
          s1 <= d[i];
          s2 <= s1;
          s3 <= s2;
          if (agree)
            q[i] <= s3;
        end
      end
    end
  endgenerate

endmodule // ebc_sync

`default_nettype wire

// File: logic/ebc_wait.sv
`timescale 1ns/10ps
`include "ebc_cfg.svh"
`default_nettype none

module ebc_wait
#(
  parameter int WAIT_W = `EBC_WAIT_W
)
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  ebc_wait_if.timer wt
);

  logic [WAIT_W-1:0] cnt;
  logic              busy;
  logic              msc_low;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire last_wait = busy && (cnt == WAIT_W'(`EBC_LAST_WAIT));
  wire multi     = (wt.count >= WAIT_W'(`EBC_RDY_MIN_WAITS));
  wire more_left = busy && (cnt > WAIT_W'(`EBC_MSC_ABOVE));
  wire start_any = wt.start && (wt.count != '0);

  wire [WAIT_W-1:0] next_cnt = wt.start ? wt.count
                             : busy     ? cnt - 1'b1
                             : cnt;

  assign wt.busy    = busy;
  assign wt.done    = last_wait;
  assign wt.msc_low = msc_low;

  // ----------------------------------------
  // Software wait counter
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt     <= WAIT_W'(`EBC_WAIT_RST);
      busy    <= 1'b0;
      msc_low <= 1'b0;
    end
    else
    begin
      cnt     <= next_cnt;
      busy    <= start_any || (busy && !last_wait);
      msc_low <= wt.start ? multi : more_left;
    end
  end

endmodule // ebc_wait

`default_nettype wire

// File: testbench/ebc_top_properties.sv
`timescale 1ns/10ps
`default_nettype none

module ebc_top_properties
#(
  parameter int WAIT_W = 3
)
(
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic [WAIT_W-1:0] req_waits,
  input wire logic              rsp_done,
  input wire logic              output_float_n,
  input wire logic              data_space_select_n,
  input wire logic              program_space_select_n,
  input wire logic              io_space_select_n,
  input wire logic              space_select_oe,
  input wire logic              memory_access_strobe_n,
  input wire logic              io_access_strobe_n,
  input wire logic              strobe_oe,
  input wire logic              read_write_n,
  input wire logic              read_write_oe,
  input wire logic              ext_address_oe,
  input wire logic              ext_data_oe,
  input wire logic              bus_release_ack_n,
  input wire logic              wait_states_complete_n
);
  // ----------------------------------------
  // Bus control properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  logic take;
  logic sel_any;
  assign take    = req_valid & req_ready;
  assign sel_any = !(data_space_select_n & program_space_select_n &
                     io_space_select_n);

  property p_one_sel;
    $countones({~data_space_select_n, ~program_space_select_n,
                ~io_space_select_n}) <= 1;
  endproperty
  a_one_sel: assert property (p_one_sel)
    else $error("more than one space select low");

  property p_mem_strb;
    !memory_access_strobe_n |-> io_space_select_n &&
      !(data_space_select_n && program_space_select_n);
  endproperty
  a_mem_strb: assert property (p_mem_strb)
    else $error("memory strobe without memory select");

  property p_io_strb;
    !io_access_strobe_n |-> !io_space_select_n && memory_access_strobe_n;
  endproperty
  a_io_strb: assert property (p_io_strb)
    else $error("io strobe without io select");

  property p_rw;
    !read_write_n |-> !(memory_access_strobe_n && io_access_strobe_n);
  endproperty
  a_rw: assert property (p_rw)
    else $error("write direction outside an access");

  property p_sel_addr;
    sel_any |-> ext_address_oe;
  endproperty
  a_sel_addr: assert property (p_sel_addr)
    else $error("select low without address driven");

  property p_hold;
    !bus_release_ack_n |-> !(space_select_oe | strobe_oe | read_write_oe |
                             ext_address_oe | ext_data_oe);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus driven during hold");

  property p_float;
    !output_float_n [*5] |-> !(space_select_oe | strobe_oe | read_write_oe);
  endproperty
  a_float: assert property (p_float)
    else $error("control driven while float requested");

  property p_fast;
    take && req_waits == '0 |-> ##1 !rsp_done ##1 rsp_done;
  endproperty
  a_fast: assert property (p_fast)
    else $error("zero wait access latency wrong");

  property p_one_wait;
    take && req_waits == 3'h1 |-> ##1 !rsp_done ##1 !rsp_done ##1 rsp_done;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("single wait access latency wrong");

  property p_sw;
    take && req_waits == 3'h2 |-> !rsp_done [*5];
  endproperty
  a_sw: assert property (p_sw)
    else $error("access ended before software waits");

  property p_msc;
    take && req_waits == 3'h2 |-> ##1 wait_states_complete_n
      ##1 !wait_states_complete_n ##1 wait_states_complete_n;
  endproperty
  a_msc: assert property (p_msc)
    else $error("wait complete output timing wrong");

  property p_grant;
    $fell(bus_release_ack_n) |-> $past(memory_access_strobe_n) &&
      $past(io_access_strobe_n);
  endproperty
  a_grant: assert property (p_grant)
    else $error("hold granted mid transfer");
endmodule // ebc_top_properties

bind ebc_top ebc_top_properties #(.WAIT_W(WAIT_W)) ebc_top_properties_i
(
  .clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
  .req_ready(req_ready), .req_waits(req_waits), .rsp_done(rsp_done),
  .output_float_n(output_float_n),
  .data_space_select_n(data_space_select_n),
  .program_space_select_n(program_space_select_n),
  .io_space_select_n(io_space_select_n),
  .space_select_oe(space_select_oe),
  .memory_access_strobe_n(memory_access_strobe_n),
  .io_access_strobe_n(io_access_strobe_n), .strobe_oe(strobe_oe),
  .read_write_n(read_write_n), .read_write_oe(read_write_oe),
  .ext_address_oe(ext_address_oe), .ext_data_oe(ext_data_oe),
  .bus_release_ack_n(bus_release_ack_n),
  .wait_states_complete_n(wait_states_complete_n)
);

`default_nettype wire

// File: testbench/ebc_ext_model.sv
`timescale 1ns/10ps
`default_nettype none

module ebc_ext_model
(
  input  wire logic        clk_sys,
  input  wire logic        slow,
  input  wire logic        memory_access_strobe_n,
  input  wire logic        io_access_strobe_n,
  input  wire logic        read_write_n,
  input  wire logic [22:0] ext_address_lines,
  input  wire logic [15:0] ext_data_lines,
  input  wire logic        ext_data_oe,
  output var  logic [15:0] ext_data_in,
  output var  logic        ext_ready
);
  // ----------------------------------------
  // Memory and I/O store with slow ready
  // ----------------------------------------
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [1:0]  cnt  = 2'h0;
  logic        act;
  logic [3:0]  a;
  assign act = !(memory_access_strobe_n && io_access_strobe_n);
  assign a   = ext_address_lines[3:0];
  // Released data bus shows the inverse of the last word
  assign ext_data_in = (act && read_write_n) ? mem[a] : ~last;
  // Not ready for the first two strobed cycles when slow
  assign ext_ready = !slow || cnt == 2'h2;

  always @(posedge clk_sys)
  begin
    cnt <= act ? cnt + 2'(cnt != 2'h2) : 2'h0;
    if (act && read_write_n)
      last <= mem[a];
    if (act && !read_write_n && ext_data_oe)
      mem[a] <= ext_data_lines;
  end
endmodule // ebc_ext_model

`default_nettype wire

// File: testbench/test_external_bus_control.sv
`timescale 1ns/10ps
`default_nettype none

module test_external_bus_control
  import ebc_pkg::*;
;
  logic        clk_sys, nrst, req_valid, req_write, req_ready, rsp_done;
  logic        ext_ready, slow, bus_release_req_n, output_float_n;
  ebc_space_t  req_space;
  logic [22:0] req_addr, ext_address_lines;
  logic [15:0] req_wdata, rsp_rdata, ext_data_in, ext_data_lines;
  logic [2:0]  req_waits;
  logic        data_space_select_n, program_space_select_n;
  logic        io_space_select_n, space_select_oe, memory_access_strobe_n;
  logic        io_access_strobe_n, strobe_oe, read_write_n, read_write_oe;
  logic        ext_address_oe, ext_data_oe, bus_release_ack_n;
  logic        bus_release_ack_oe, wait_states_complete_n;
  logic        wait_states_complete_oe;
  int          fails, checks_done, cyc;
  integer      seed = 1;
  logic [16:0] q [$];
  logic [16:0] e;
  logic [15:0] shadow [16];
  logic [2:0]  wt [4] = '{3'h0, 3'h1, 3'h2, 3'h5};

  ebc_top ebc_top_i
  (
    .clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_space(req_space), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_waits(req_waits),
    .rsp_done(rsp_done), .rsp_rdata(rsp_rdata), .ext_ready(ext_ready),
    .bus_release_req_n(bus_release_req_n), .output_float_n(output_float_n),
    .data_space_select_n(data_space_select_n),
    .program_space_select_n(program_space_select_n),
    .io_space_select_n(io_space_select_n),
    .space_select_oe(space_select_oe),
    .memory_access_strobe_n(memory_access_strobe_n),
    .io_access_strobe_n(io_access_strobe_n), .strobe_oe(strobe_oe),
    .read_write_n(read_write_n), .read_write_oe(read_write_oe),
    .ext_address_lines(ext_address_lines), .ext_address_oe(ext_address_oe),
    .ext_data_in(ext_data_in), .ext_data_lines(ext_data_lines),
    .ext_data_oe(ext_data_oe), .bus_release_ack_n(bus_release_ack_n),
    .bus_release_ack_oe(bus_release_ack_oe),
    .wait_states_complete_n(wait_states_complete_n),
    .wait_states_complete_oe(wait_states_complete_oe)
  );

  ebc_ext_model ebc_ext_model_i
  (
    .clk_sys(clk_sys), .slow(slow),
    .memory_access_strobe_n(memory_access_strobe_n),
    .io_access_strobe_n(io_access_strobe_n), .read_write_n(read_write_n),
    .ext_address_lines(ext_address_lines), .ext_data_lines(ext_data_lines),
    .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
    .ext_ready(ext_ready)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic acc(input int sp, input logic wr, input logic [3:0] a,
                     input logic [2:0] w);
    logic [15:0] d;
    d = 16'($random(seed));
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_space <= ebc_space_t'(sp);
    req_write <= wr;
    req_addr  <= {19'h0, a};
    req_wdata <= d;
    req_waits <= w;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    if (wr)
      shadow[a] = d;
    q.push_back({!wr, wr ? 16'h0 : shadow[a]});
  endtask

  task automatic wait_ack(input logic v);
    int n;
    n = 0;
    while (bus_release_ack_n !== v && n < 40)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(16'(bus_release_ack_n), 16'(v));
  endtask

  // ----------------------------------------
  // Clock, monitor and timeout
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (nrst && rsp_done === 1'b1)
    begin
      e = (q.size() == 0) ? 17'h1ffff : q.pop_front();
      if (e[16])
        chk(rsp_rdata, e[15:0]);
    end
    if (cyc == 5000)
    begin
      fails++;
      conclude();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {nrst, req_valid, req_write, slow} = 4'h0;
    {bus_release_req_n, output_float_n} = 2'h3;
    req_space = EBC_SP_DATA;
    {req_addr, req_wdata, req_waits} = '0;
    repeat (3) @(posedge clk_sys);
    chk(16'({bus_release_ack_n, data_space_select_n, program_space_select_n,
      io_space_select_n, memory_access_strobe_n, io_access_strobe_n,
      read_write_n, ext_data_oe}), 16'h00fe);
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    $display("test reset done");
    for (int i = 0; i < 24; i++)
    begin
      slow <= i[2];
      acc(i % 3, i < 12, 4'(i % 12), wt[i % 4]);
    end
    for (int n = 0; n < 40 && q.size() != 0; n++)
      @(posedge clk_sys);
    chk(16'(q.size()), 16'h0);
    $display("test access done");
    acc(0, 1'b1, 4'h0, 3'h5);
    bus_release_req_n <= 1'b0;
    wait_ack(1'b0);
    chk(16'({space_select_oe, strobe_oe, read_write_oe, ext_address_oe,
      ext_data_oe}), 16'h0);
    repeat (4) @(posedge clk_sys);
    bus_release_req_n <= 1'b1;
    wait_ack(1'b1);
    acc(0, 1'b0, 4'h0, 3'h2);
    while (q.size() != 0)
      @(posedge clk_sys);
    $display("test hold done");
    output_float_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(16'({space_select_oe, strobe_oe, read_write_oe, bus_release_ack_oe,
      wait_states_complete_oe}), 16'h0);
    output_float_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    $display("test float done");
    conclude();
  end
endmodule // test_external_bus_control

`default_nettype wire
